// >>> shared/log_area_consts.vh
// Constants for the recorder log area formatter: disk addresses,
// area sizes, byte positions inside a sector and fixed byte values.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LOG_AREA_CONSTS_VH
`define LOG_AREA_CONSTS_VH

// Error-correction block address range of the log area
`define LOG_AREA_ADDR_HI 24'hFFDFC3
`define LOG_AREA_ADDR_LO 24'hFFDD07

// Sizes in bytes and sectors
`define SECTOR_BYTES 12'h800
`define SECTORS_PER_SET 5'h10
`define LEADIN_BYTES 16'h8000
`define RESERVED_BYTES 16'h4000
`define RESERVED_SECTORS 4'h8

// Identity unit: writer-chosen ranges, all other bytes zero
`define ID_MAKER_A_LO 11'h000
`define ID_MAKER_A_HI 11'h01F
`define ID_SERIAL_LO 11'h028
`define ID_SERIAL_HI 11'h037
`define ID_MODEL_LO 11'h040
`define ID_MODEL_HI 11'h04F
`define ID_MAKER_B_LO 11'h058
`define ID_MAKER_B_HI 11'h069

// Log data set sector numbers
`define SEC_LINK_LOSS 4'h0
`define SEC_GENERAL 4'h1

// General sector byte positions
`define GEN_FMT_HI 11'h000
`define GEN_FMT_LO 11'h001
`define GEN_STATUS 11'h002
`define GEN_MAKER_LO 11'h004
`define GEN_MAKER_HI 11'h015
`define GEN_TAG1 11'h016
`define GEN_TAG2 11'h01E
`define GEN_TAG3 11'h026
`define GEN_TAG4 11'h02E
`define GEN_TAG5 11'h036
`define GEN_COPY_END 11'h03C
// Zero bytes that close the copied subblocks
`define GEN_PAD1 11'h01D
`define GEN_PAD2 11'h025
`define GEN_PAD3 11'h02D
`define GEN_PAD4 11'h035

// Fixed byte values
`define LOG_FORMAT_WORD 16'h0001
`define STATUS_EMPTY 8'h00
`define STATUS_ONE_PASS 8'h01
`define STATUS_INCR 8'h02
`define STATUS_FINAL 8'h03
`define ZERO_BYTE 8'h00
`define TAG1 8'h01
`define TAG2 8'h02
`define TAG3 8'h03
`define TAG4 8'h04
`define TAG5 8'h05

`endif

// >>> core/log_byte_source.v
// Byte map of the recorder log area: for one sector and byte offset it
// gives the byte to record and whether that byte has a required value.
// Assumes the caller supplies the writer-chosen bytes for the position.
`timescale 1ns/1ps
`include "log_area_consts.vh"

module log_byte_source (
  // Position
  input wire data_set,
  input wire [3:0] sector,
  input wire [10:0] offset,
  // Writer-chosen and controller values
  input wire [7:0] status,
  input wire [7:0] id_byte,
  input wire [7:0] gen_byte,
  input wire [7:0] field_byte,
  // Result
  output reg [7:0] exp_byte,
  output reg exp_fixed,
  output reg at_status,
  output reg needs_field
);

  function in_range;
    input [10:0] o;
    input [10:0] lo;
    input [10:0] hi;
    begin
      in_range = (o >= lo) && (o <= hi);
    end
  endfunction

  wire [15:0] fmt = `LOG_FORMAT_WORD;

  ////////////////////////////////////////////////////////////////////////
  // Position decode; everything not named below is a zero byte
  always @* begin
    exp_byte = `ZERO_BYTE;
    exp_fixed = 1'b1;
    at_status = 1'b0;
    needs_field = 1'b0;
    if (!data_set) begin
      if (sector >= `RESERVED_SECTORS) begin
        // Same table for all eight units keeps them identical
        if (in_range(offset, `ID_MAKER_A_LO, `ID_MAKER_A_HI) ||
            in_range(offset, `ID_SERIAL_LO, `ID_SERIAL_HI) ||
            in_range(offset, `ID_MODEL_LO, `ID_MODEL_HI) ||
            in_range(offset, `ID_MAKER_B_LO, `ID_MAKER_B_HI)) begin
          exp_byte = id_byte;
          exp_fixed = 1'b0;
        end
      end
    end else if (sector == `SEC_GENERAL) begin
      case (offset)
        `GEN_FMT_HI: exp_byte = fmt[15:8];
        `GEN_FMT_LO: exp_byte = fmt[7:0];
        `GEN_STATUS: begin
          exp_byte = status;
          exp_fixed = 1'b0;
          at_status = 1'b1;
        end
        `GEN_TAG1: exp_byte = `TAG1;
        `GEN_TAG2: exp_byte = `TAG2;
        `GEN_TAG3: exp_byte = `TAG3;
        `GEN_TAG4: exp_byte = `TAG4;
        `GEN_TAG5: exp_byte = `TAG5;
        default: begin
          // Zero holes at 3, 29, 37, 45, 53 and from 61 on
          if (in_range(offset, `GEN_MAKER_LO, `GEN_COPY_END) &&
              offset != `GEN_PAD1 && offset != `GEN_PAD2 &&
              offset != `GEN_PAD3 && offset != `GEN_PAD4) begin
            exp_byte = gen_byte;
            exp_fixed = 1'b0;
          end
        end
      endcase
    end else if (sector != `SEC_LINK_LOSS) begin
      exp_byte = field_byte;
      exp_fixed = 1'b0;
      needs_field = 1'b1;
    end
  end

endmodule

// >>> core/recorder_log_area_formatter.v
// Recorder log area formatter: builds the log lead-in block and the
// sixteen-sector log data sets byte by byte, or checks them on read-back.
// Assumes one byte clock; controller and channel logic share that clock.
`timescale 1ns/1ps
`include "log_area_consts.vh"

module recorder_log_area_formatter #(
  parameter SECTOR_BYTES = 2048,
  parameter SECTORS = 16,
  parameter TABLE_DEPTH = 128
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Block request from the controller
  input wire start,
  input wire data_set,
  input wire check_mode,
  input wire incremental,
  input wire [23:0] block_addr,
  input wire [7:0] disk_status,
  // Table load: identity unit bytes and general sector bytes
  input wire id_wr_en,
  input wire gen_wr_en,
  input wire [6:0] table_addr,
  input wire [7:0] table_data,
  // Log field bytes for sectors 2 to 15
  input wire [7:0] field_data,
  input wire field_valid,
  output wire field_ready,
  // Byte stream to the channel encoder
  output reg [7:0] out_data,
  output reg out_valid,
  input wire out_ready,
  output reg out_first,
  output reg out_last,
  output reg [3:0] out_sector,
  // Read-back stream in check mode
  input wire [7:0] rb_data,
  input wire rb_valid,
  output wire rb_ready,
  // Status
  output reg busy,
  output reg done,
  output reg rejected,
  output reg check_error,
  output reg single_sector_linking,
  output reg [23:0] ecc_addr
);

  localparam IDLE = 2'b00;
  localparam RUN = 2'b01;
  localparam DRAIN = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function status_ok;
    input [7:0] s;
    begin
      status_ok = (s == `STATUS_EMPTY) || (s == `STATUS_ONE_PASS) ||
        (s == `STATUS_INCR) || (s == `STATUS_FINAL);
    end
  endfunction

  function addr_ok;
    input [23:0] a;
    begin
      addr_ok = (a <= `LOG_AREA_ADDR_HI) && (a >= `LOG_AREA_ADDR_LO);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  reg [1:0] state;
  reg [1:0] next_state;
  reg mode_data;
  reg mode_check;
  reg [7:0] status_held;
  reg [3:0] sector;
  reg [10:0] offset;
  reg [7:0] id_mem [0:TABLE_DEPTH-1];
  reg [7:0] gen_mem [0:TABLE_DEPTH-1];

  wire [7:0] exp_byte;
  wire exp_fixed;
  wire at_status;
  wire needs_field;
  wire last_byte;
  wire last_sector;
  wire stage_free;
  wire advance;
  wire byte_bad;

  ////////////////////////////////////////////////////////////////////////
  // Tables written by the controller
  // Writes while busy are dropped so every identity unit in a block
  // sees the same bytes, even if software reloads mid-block.
  always @(posedge ref_clk) begin
    if (id_wr_en && state == IDLE) begin
      id_mem[table_addr] <= table_data;
    end
    if (gen_wr_en && state == IDLE) begin
      gen_mem[table_addr] <= table_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte map

  log_byte_source u_map (
    .data_set(mode_data),
    .sector(sector),
    .offset(offset),
    .status(status_held),
    .id_byte(id_mem[offset[6:0]]),
    .gen_byte(gen_mem[offset[6:0]]),
    .field_byte(field_data),
    .exp_byte(exp_byte),
    .exp_fixed(exp_fixed),
    .at_status(at_status),
    .needs_field(needs_field)
  );

  ////////////////////////////////////////////////////////////////////////
  // Handshakes
  // The output stage holds one byte; it refills as it is taken, so a
  // ready channel sees one byte per clock with no bubble.
  assign stage_free = !out_valid || out_ready;
  assign last_byte = (offset == SECTOR_BYTES - 1);
  assign last_sector = (sector == SECTORS - 1);

  assign field_ready = (state == RUN) && !mode_check && needs_field &&
    stage_free;
  assign rb_ready = (state == RUN) && mode_check;

  assign advance = (state == RUN) && (mode_check ? rb_valid :
    (stage_free && (!needs_field || field_valid)));

  // A required byte that reads back different, or an undefined status
  assign byte_bad = (exp_fixed && rb_data != exp_byte) ||
    (at_status && !status_ok(rb_data));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state

  always @* begin
    next_state = state;
    case (state)
      IDLE: begin
        if (start && status_ok(disk_status) && addr_ok(block_addr)) begin
          next_state = RUN;
        end
      end
      RUN: begin
        if (advance && last_byte && last_sector) begin
          next_state = DRAIN;
        end
      end
      DRAIN: begin
        // Done only once the channel has taken the final byte
        if (!out_valid || out_ready) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request capture, address and position counters

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_data <= 1'b0;
      mode_check <= 1'b0;
      status_held <= `STATUS_EMPTY;
      sector <= 4'h0;
      offset <= 11'h000;
      ecc_addr <= 24'h000000;
      single_sector_linking <= 1'b0;
    end else if (state == IDLE) begin
      if (start && status_ok(disk_status) &&
          addr_ok(block_addr)) begin
        mode_data <= data_set;
        mode_check <= check_mode;
        status_held <= disk_status;
        ecc_addr <= block_addr;
        // Appended data sets link one sector at a time
        single_sector_linking <= data_set && incremental;
        sector <= 4'h0;
        offset <= 11'h000;
      end
    end else if (advance) begin
      if (last_byte) begin
        offset <= 11'h000;
        sector <= sector + 4'h1;
      end else begin
        offset <= offset + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage toward the channel encoder

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      out_data <= `ZERO_BYTE;
      out_valid <= 1'b0;
      out_first <= 1'b0;
      out_last <= 1'b0;
      out_sector <= 4'h0;
    end else if (advance && !mode_check) begin
      // Reserved half and all zero holes come straight from the map
      out_data <= exp_byte;
      out_valid <= 1'b1;
      out_first <= (offset == 11'h000);
      out_last <= last_byte;
      out_sector <= sector;
    end else if (out_ready) begin
      out_valid <= 1'b0;
      out_first <= 1'b0;
      out_last <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs
  // The check flag is sticky until the next accepted request so a slow
  // controller still sees a single bad byte in a long block.

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rejected <= 1'b0;
      check_error <= 1'b0;
    end else begin
      busy <= (next_state != IDLE);
      done <= (state == DRAIN) && (next_state == IDLE);
      rejected <= (state == IDLE) && start &&
        !(status_ok(disk_status) && addr_ok(block_addr));
      if (advance && mode_check && byte_bad) begin
        check_error <= 1'b1;
      end else if (state == IDLE && start && status_ok(disk_status) &&
          addr_ok(block_addr)) begin
        check_error <= 1'b0;
      end
    end
  end

endmodule

// >>> bench/log_area_checker_asserts.sv
// Checker for the log area formatter: refusals, stream order, fixed bytes.
// Assumes it is bound to the formatter and sees only its ports.
`timescale 1ns/1ps
`include "log_area_consts.vh"

module log_area_checker (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Request
  input wire start,
  input wire data_set,
  input wire incremental,
  input wire [23:0] block_addr,
  input wire [7:0] disk_status,
  // Stream and status
  input wire [7:0] out_data,
  input wire out_valid,
  input wire out_ready,
  input wire out_first,
  input wire out_last,
  input wire [3:0] out_sector,
  input wire busy,
  input wire done,
  input wire rejected,
  input wire single_sector_linking,
  input wire [23:0] ecc_addr
);
  logic [10:0] pos;
  logic ds;
  logic [7:0] st;
  wire req = start && !busy;
  wire legal = block_addr <= `LOG_AREA_ADDR_HI &&
    block_addr >= `LOG_AREA_ADDR_LO && disk_status <= 8'h03;
  wire take = out_valid && out_ready;
  wire gen = out_valid && ds && out_sector == 4'h1;

  // Byte position and request values, restarted by each accepted block
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pos <= 11'h000;
      ds <= 1'b0;
      st <= 8'h00;
    end else if (req && legal) begin
      pos <= 11'h000;
      ds <= data_set;
      st <= disk_status;
    end else if (take) begin
      pos <= out_last ? 11'h000 : pos + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req_ok;
    req && legal;
  endsequence
  sequence s_take_last;
    take && out_last && out_sector == 4'hF;
  endsequence
  property p_refuse;
    req && !legal |=> rejected && !busy;
  endproperty
  property p_accept;
    s_req_ok |=> busy && !rejected && ecc_addr == $past(block_addr);
  endproperty
  property p_link;
    s_req_ok |=> single_sector_linking ==
      ($past(data_set) && $past(incremental));
  endproperty
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data) &&
      $stable(out_sector) && $stable(out_first);
  endproperty
  property p_edges;
    out_valid |-> out_first == (pos == 11'h000) &&
      out_last == (pos == 11'h7FF);
  endproperty
  property p_done;
    s_take_last |=> done && !busy;
  endproperty
  property p_reserved;
    out_valid && !ds && out_sector < 4'h8 |-> out_data == 8'h00;
  endproperty
  property p_format;
    gen && pos < 11'h002 |-> out_data == {7'h00, pos[0]};
  endproperty
  property p_status;
    gen && pos == 11'h002 |-> out_data == st;
  endproperty
  property p_tail;
    gen && pos > 11'h03C |-> out_data == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad request taken");
  a_accept: assert property (p_accept) else $error("request lost");
  a_link: assert property (p_link) else $error("linking not set");
  a_hold: assert property (p_hold) else $error("stalled byte moved");
  a_edges: assert property (p_edges) else $error("sector flags off");
  a_done: assert property (p_done) else $error("block end missed");
  a_reserved: assert property (p_reserved) else $error("reserved byte");
  a_format: assert property (p_format) else $error("format word");
  a_status: assert property (p_status) else $error("status byte");
  a_tail: assert property (p_tail) else $error("tail not zero");
endmodule

bind recorder_log_area_formatter log_area_checker checker_inst (.*);

// >>> bench/channel_sink.sv
// Channel encoder model: accepts formatter bytes, stalling on request.
// Assumes the formatter's byte clock; counts every byte it accepts.
`timescale 1ns/1ps

module channel_sink (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Bench control
  input wire slow,
  // Byte stream
  input wire out_valid,
  output logic out_ready,
  output logic [15:0] n_taken
);
  logic [3:0] tick;

  // Ready drops one cycle in sixteen when slow, so stalls land mid-sector
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tick <= 4'h0;
      out_ready <= 1'b0;
      n_taken <= 16'h0000;
    end else begin
      tick <= tick + 4'h1;
      out_ready <= !(slow && tick == 4'hE);
      if (out_valid && out_ready) begin
        n_taken <= n_taken + 16'h0001;
      end
    end
  end
endmodule

// >>> bench/testbench.sv
// Testbench: emits a lead-in and a data set, tries refusals and read-back.
// Assumes the channel model and the bound checker sit beside the design.
`timescale 1ns/1ps
`include "log_area_consts.vh"

module testbench;
  logic ref_clk, rst_n, start, data_set, check_mode, incremental, slow;
  logic id_wr_en, gen_wr_en, field_valid, rb_valid;
  logic [23:0] block_addr;
  logic [7:0] disk_status, table_data, field_data, rb_data;
  logic [6:0] table_addr;
  wire field_ready, out_valid, out_ready, out_first, out_last, rb_ready;
  wire busy, done, rejected, check_error, single_sector_linking;
  wire [7:0] out_data;
  wire [3:0] out_sector;
  wire [23:0] ecc_addr;
  wire [15:0] n_taken;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  recorder_log_area_formatter dut (.*);
  channel_sink sink (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Field source steps its byte each time one is consumed
  always @(posedge ref_clk) begin
    if (field_valid && field_ready) begin
      field_data <= field_data + 8'h01;
    end
  end

  // Cycle ceiling: two whole blocks plus read-back, with margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic compare(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Table content is never zero, so a missed copy shows as a zero byte
  function automatic logic [7:0] tv(input logic [10:0] o);
    return o[7:0] ^ 8'hA5;
  endfunction

  function automatic logic [7:0] exp_byte(input logic ds,
      input logic [3:0] s, input logic [10:0] o, input logic [7:0] st);
    logic w;
    w = o < 32 || (o >= 40 && o < 56) || (o >= 64 && o < 80) ||
      (o >= 88 && o < 106);
    if (!ds) return (s >= 4'h8 && w) ? tv(o) : 8'h00;
    if (s != 4'h1 || o > 60) return 8'h00;
    case (o)
      0, 3, 29, 37, 45, 53: return 8'h00;
      1, 22: return 8'h01;
      2: return st;
      30: return 8'h02;
      38: return 8'h03;
      46: return 8'h04;
      54: return 8'h05;
      default: return tv(o);
    endcase
  endfunction

  task automatic request(input logic ds, cm, inc, input logic [23:0] a,
      input logic [7:0] st);
    @(posedge ref_clk);
    start <= 1'b1;
    data_set <= ds;
    check_mode <= cm;
    incremental <= inc;
    block_addr <= a;
    disk_status <= st;
    @(posedge ref_clk);
    start <= 1'b0;
  endtask

  // Emit one whole block and judge every byte against the byte map
  task automatic emit(input logic ds, input logic [23:0] a,
      input logic [7:0] st);
    logic [3:0] s;
    logic [10:0] o;
    logic [7:0] f;
    logic [15:0] n0;
    s = 4'h0;
    o = 11'h000;
    f = field_data;
    n0 = n_taken;
    // Raised after the request edge, so a block that follows another
    // never drives these twice in one time step
    request(ds, 1'b0, ds, a, st);
    slow <= ds;
    field_valid <= ds;
    @(posedge ref_clk);
    compare(ecc_addr, a);
    compare(single_sector_linking, ds);
    while (!done) begin
      @(posedge ref_clk);
      if (out_valid && out_ready) begin
        compare(out_sector, s);
        compare(out_first, o == 11'h000);
        compare(out_last, o == 11'h7FF);
        compare(out_data, (ds && s > 1) ? f : exp_byte(ds, s, o, st));
        f = f + {7'h00, ds && s > 1};
        s = s + {3'h0, o == 11'h7FF};
        o = o + 11'h001;
      end
    end
    compare(busy, 1'b0);
    // Subtract at 16 bits: the byte count wraps during the second block
    n0 = n_taken - n0;
    compare(n0, 16'h8000);
    compare({s, o}, 15'h0000);
    field_valid <= 1'b0;
    slow <= 1'b0;
  endtask

  // Out-of-range addresses and undefined status codes are refused
  task automatic refuse();
    logic [23:0] a [4] = '{24'hFFDFC4, 24'hFFDD06, 24'hFFDFC3, 24'hFFDD07};
    logic [7:0] st [4] = '{8'h00, 8'h03, 8'h04, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      request(1'b1, 1'b0, 1'b0, a[i], st[i]);
      @(posedge ref_clk);
      compare({rejected, busy}, 2'h2);
    end
  endtask

  // Feed read-back up to one chosen byte, judge, then abort by reset
  task automatic readback(input logic ds, input int pos,
      input logic [7:0] v, input logic err);
    request(ds, 1'b1, 1'b0, `LOG_AREA_ADDR_LO, 8'h02);
    for (int i = 0; i <= pos; i++) begin
      rb_valid <= 1'b1;
      rb_data <= (i == pos) ? v : {7'h00, ds && i == 2049};
      @(posedge ref_clk);
      while (!rb_ready) @(posedge ref_clk);
    end
    rb_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    compare(check_error, err);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    compare({busy, check_error}, 2'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, start, data_set, check_mode, incremental, slow} = 6'h00;
    {id_wr_en, gen_wr_en, field_valid, rb_valid} = 4'h0;
    block_addr = 24'h000000;
    {disk_status, table_data, field_data, rb_data} = 32'h00000000;
    table_addr = 7'h00;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 128; a++) begin
      @(posedge ref_clk);
      {id_wr_en, gen_wr_en} <= 2'h3;
      table_addr <= a[6:0];
      table_data <= tv(a[10:0]);
    end
    @(posedge ref_clk);
    {id_wr_en, gen_wr_en} <= 2'h0;
    emit(1'b0, `LOG_AREA_ADDR_HI, 8'h01);
    emit(1'b1, `LOG_AREA_ADDR_LO, 8'h02);
    refuse();
    readback(1'b0, 5, 8'h11, 1'b1);
    for (int st = 0; st < 5; st++) begin
      readback(1'b1, 2050, st[7:0], st > 3);
    end
    readback(1'b1, 2049, 8'h00, 1'b1);
    readback(1'b1, 2052, 8'h5A, 1'b0);
    readback(1'b1, 2070, 8'h00, 1'b1);
    tally_and_finish();
  end
endmodule
